/* logic/ats_map.svh */
/*
 Register offsets, reset values and timing counts of the converter and
 touch screen control block. Assumes inclusion by bare name.
*/
`ifndef ATS_MAP_SVH
`define ATS_MAP_SVH

// Byte offsets on the register bus (one aligned word each)
`define ATS_OFF_CTRL     12'h000
`define ATS_OFF_TSC      12'h004
`define ATS_OFF_DAT0     12'h00C
`define ATS_OFF_DAT1     12'h010

// Reset values
`define ATS_CTRL_RST     16'h3FC4
`define ATS_TSC_RST      9'h058
`define ATS_DAT_RST      10'h000

// Converter clock cycles per conversion
`define ATS_CONV_TICKS   3'h5
`define ATS_TICK_ONE     3'h1

// Channel codes used by the position measurements
`define ATS_CHAN_YP      3'h5
`define ATS_CHAN_XP      3'h7

// Widths of the readable words
`define ATS_CTRL_W       16
`define ATS_TSC_W        9
`define ATS_DAT_W        10

`endif

/* logic/ats_pkg.sv */
/*
 Types of the converter and touch screen control block: register field
 layouts, mode codes, sequencer states and the pad switch bundle.
 Assumes nothing of its surroundings.
*/
`default_nettype none

package ats_pkg;

    // Converter control register layout
    typedef struct packed {
        logic       done;
        logic       psc_en;
        logic [7:0] psc_val;
        logic [2:0] chan;
        logic       standby;
        logic       start_read;
        logic       start_en;
    } ats_ctrl_t;

    // Position select codes
    typedef enum logic [1:0] {
        ATS_POS_NOP  = 2'h0,
        ATS_POS_X    = 2'h1,
        ATS_POS_Y    = 2'h2,
        ATS_POS_WAIT = 2'h3
    } ats_pos_t;

    // Touch control register layout (switch bits as stored)
    typedef struct packed {
        logic     ud_sel;
        logic     ym_en;
        logic     yp_dis_n;
        logic     xm_en;
        logic     xp_dis_n;
        logic     pull_dis_n;
        logic     auto_seq;
        ats_pos_t pos;
    } ats_tsc_t;

    // Pad switch controls, high = switch closed
    typedef struct packed {
        logic xp_drive;
        logic xm_drive;
        logic yp_drive;
        logic ym_drive;
        logic xp_pullup;
    } ats_pads_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ATS_ST_IDLE = 3'h1,
        ATS_ST_CONV = 3'h2,
        ATS_ST_HOLD = 3'h4
    } ats_state_t;

endpackage : ats_pkg

`default_nettype wire

/* logic/ats_top.sv */
/*
 Converter and touch screen control block: APB register slave, prescaler,
 conversion sequencer, pad switch control and interrupt pulses.
 Assumes an analog core that converts conv_channel on each conv_tick while
 conv_busy is high and presents its 10-bit code on conv_code by the fifth
 tick, and a stylus comparator level on stylus_down.
*/
// Overview of operation
// R1: Select one of eight inputs; each result is a 10-bit code.
// R2: Converter clock is source clock over prescale plus one; five cycles each.
// R3: Software keeps the converter clock at or below 2.5 MHz.
// R4: Pad switch control, converter interface and interrupt generation together.
// R5: Normal conversion starts by control write, ends on result read then write.
// R6: X mode stores result in first register, then raises interrupt.
// R7: Y mode stores result in second register, then raises interrupt.
// R8: Auto mode converts X then Y, one interrupt after both stores.
// R9: Wait mode raises touch interrupt when the stylus goes down.
// R10: Software writes 0xd3 to touch control to enter wait mode.
// R11: Software leaves wait mode by setting position select to no operation.
// R12: Standby bit 2 halts conversion, results keep their old data.
// R13: Done flag at control bit 15 for polling or interrupt use.
// R14: With start-on-read bit 1 set, each result read starts a conversion.
// R15: Minus pads act as plain analog inputs without a touch screen.
// R16: Channel field 5:3 selects inputs 0..3, then Y-, Y+, X-, X+.
// R17: Prescaler divides only with bit 14 set; 8-bit value, resets to ones.
// R18: Enable-start bit 0 starts and self-clears; ignored under start-on-read.
// R19: Position codes: none, X, Y, wait for interrupt.
// R20: Done flag sets on result store, clears when a conversion starts.
`timescale 1ns/1ps
`default_nettype none
`include "ats_map.svh"

module ats_top (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Analog converter core
    output logic                   conv_tick,
    output logic                   conv_busy,
    output logic [2:0]             conv_channel,
    input  wire logic [9:0]        conv_code,
    // Touch pads
    output ats_pkg::ats_pads_t     pads,
    input  wire logic              stylus_down,
    // Interrupt sources
    output logic                   conv_interrupt,
    output logic                   touch_interrupt
);

    // Decode of the register offsets
    function automatic logic [3:0] ats_decode(input logic [11:0] addr);
        ats_decode = {addr == `ATS_OFF_DAT1, addr == `ATS_OFF_DAT0,
                      addr == `ATS_OFF_TSC,  addr == `ATS_OFF_CTRL};
    endfunction

    // Register state
    ats_pkg::ats_ctrl_t  ctrl_q, ctrl_d;
    ats_pkg::ats_tsc_t   tsc_q, tsc_d;
    logic [9:0]          dat0_q, dat0_d;
    logic [9:0]          dat1_q, dat1_d;
    logic [31:0]         rdata_q, rdata_d;
    logic                err_q, err_d;

    // Sequencer state
    ats_pkg::ats_state_t state_q, state_d;
    logic [7:0]          psc_cnt_q, psc_cnt_d;
    logic [2:0]          tick_cnt_q, tick_cnt_d;
    logic                phase_y_q, phase_y_d;
    logic                rd_seen_q, rd_seen_d;
    logic                irq_q, irq_d;

    // Touch detection state
    logic                stylus_q;
    logic                touch_irq_q, touch_irq_d;
    ats_pkg::ats_pads_t  pads_q, pads_d;
    logic [2:0]          chan_q, chan_d;

    // Bus phases
    logic       setup;
    logic       access;
    logic       wr;
    logic       rd;
    logic [3:0] hit;
    logic       start;
    logic       finish;
    logic       axis_y;
    logic       axis_on;

    // Control word as written, field by field
    ats_pkg::ats_ctrl_t  wctl;
    assign wctl = pwdata[`ATS_CTRL_W-1:0];

    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wr     = access & pwrite & ~err_q;
    assign rd     = access & ~pwrite & ~err_q;
    assign hit    = ats_decode(paddr);

    // Slave always answers in the access cycle
    assign pready  = access;
    assign pslverr = access & err_q;
    assign prdata  = rdata_q;

    // Start sources, both blocked in standby
    always_comb begin
        start = 1'b0;
        if (ctrl_q.start_read && !ctrl_q.standby) begin               // R12
            start = rd & (hit[2] | hit[3]);                          // R14
        end
        // Written word decides, so one write may leave standby and start
        if (wr && hit[0] && wctl.start_en && !wctl.start_read && !wctl.standby) begin
            start = 1'b1;                                            // R5 R12 R18
        end
    end

    // Final converter tick of a conversion
    assign finish = (state_q == ats_pkg::ATS_ST_CONV) & conv_tick
                    & (tick_cnt_q == `ATS_CONV_TICKS);               // R2

    // Axis of the current measurement
    assign axis_on = tsc_q.auto_seq | (tsc_q.pos == ats_pkg::ATS_POS_X)
                     | (tsc_q.pos == ats_pkg::ATS_POS_Y);
    assign axis_y  = tsc_q.auto_seq ? phase_y_q
                     : (tsc_q.pos == ats_pkg::ATS_POS_Y);

    // Register file next values and read data capture
    always_comb begin
        ctrl_d          = ctrl_q;
        tsc_d           = tsc_q;
        dat0_d          = dat0_q;
        dat1_d          = dat1_q;
        rdata_d         = rdata_q;
        err_d           = err_q;
        ctrl_d.start_en = 1'b0;                                      // R18
        if (setup) begin
            err_d   = ~|hit;
            rdata_d = 32'h0000_0000;
            unique case (1'b1)
                hit[0]:  rdata_d[`ATS_CTRL_W-1:0] = ctrl_q;          // R13
                hit[1]:  rdata_d[`ATS_TSC_W-1:0]  = tsc_q;
                hit[2]:  rdata_d[`ATS_DAT_W-1:0]  = dat0_q;
                hit[3]:  rdata_d[`ATS_DAT_W-1:0]  = dat1_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        if (wr && hit[0]) begin
            ctrl_d.psc_en     = wctl.psc_en;                         // R17
            ctrl_d.psc_val    = wctl.psc_val;                        // R17
            ctrl_d.chan       = wctl.chan;                           // R16
            ctrl_d.standby    = wctl.standby;                        // R12
            ctrl_d.start_read = wctl.start_read;                     // R14
        end
        if (wr && hit[1]) begin
            tsc_d = pwdata[`ATS_TSC_W-1:0];                          // R19
        end
        // Results land only from the converter
        if (finish) begin
            if (axis_on && axis_y) begin
                dat1_d = conv_code;                                  // R7 R8
            end else begin
                dat0_d = conv_code;                                  // R1 R6
            end
        end
        // Done flag: last store of a sequence sets, start clears
        if (start) begin
            ctrl_d.done = 1'b0;                                      // R20
        end
        if (finish && !(tsc_q.auto_seq && !phase_y_q)) begin
            ctrl_d.done = 1'b1;                                      // R13 R20
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `ATS_CTRL_RST;
            tsc_q   <= `ATS_TSC_RST;
            dat0_q  <= `ATS_DAT_RST;
            dat1_q  <= `ATS_DAT_RST;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            tsc_q   <= tsc_d;
            dat0_q  <= dat0_d;
            dat1_q  <= dat1_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // Converter clock: one tick every prescale value plus one cycles
    assign conv_tick = ctrl_q.psc_en & (state_q == ats_pkg::ATS_ST_CONV)
                       & (psc_cnt_q == ctrl_q.psc_val)               // R2 R17
                       & ~ctrl_q.standby;                            // R12
    assign conv_busy = (state_q == ats_pkg::ATS_ST_CONV);

    // Sequencer next state
    always_comb begin
        state_d    = state_q;
        psc_cnt_d  = psc_cnt_q;
        tick_cnt_d = tick_cnt_q;
        phase_y_d  = phase_y_q;
        rd_seen_d  = rd_seen_q;
        irq_d      = 1'b0;
        // Prescaler count, held while disabled
        if (state_q == ats_pkg::ATS_ST_CONV && ctrl_q.psc_en) begin
            psc_cnt_d = conv_tick ? 8'h00 : psc_cnt_q + 8'h01;       // R17
        end
        if (conv_tick) begin
            tick_cnt_d = tick_cnt_q + `ATS_TICK_ONE;
        end
        unique case (state_q)
            ats_pkg::ATS_ST_IDLE: begin
                if (start) begin
                    state_d = ats_pkg::ATS_ST_CONV;
                end
            end
            ats_pkg::ATS_ST_CONV: begin
                if (finish) begin
                    tick_cnt_d = `ATS_TICK_ONE;
                    psc_cnt_d  = 8'h00;
                    if (tsc_q.auto_seq && !phase_y_q) begin
                        phase_y_d = 1'b1;                            // R8
                    end else begin
                        phase_y_d = 1'b0;
                        irq_d     = 1'b1;                            // R6 R7 R8
                        rd_seen_d = 1'b0;
                        state_d   = ats_pkg::ATS_ST_HOLD;
                    end
                end
            end
            ats_pkg::ATS_ST_HOLD: begin
                // Result held until first result is read, then written
                if (rd && hit[2]) begin
                    rd_seen_d = 1'b1;
                end
                if (wr && hit[2] && rd_seen_q) begin
                    state_d = ats_pkg::ATS_ST_IDLE;                  // R5
                end
                if (start) begin
                    state_d = ats_pkg::ATS_ST_CONV;
                end
            end
        endcase
        if (start) begin
            psc_cnt_d  = 8'h00;
            tick_cnt_d = `ATS_TICK_ONE;
            phase_y_d  = 1'b0;
        end
        // Standby halts any conversion in flight
        if (ctrl_q.standby && state_q == ats_pkg::ATS_ST_CONV) begin
            state_d   = ats_pkg::ATS_ST_IDLE;                        // R12
            phase_y_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ats_pkg::ATS_ST_IDLE;
            psc_cnt_q  <= 8'h00;
            tick_cnt_q <= `ATS_TICK_ONE;
            phase_y_q  <= 1'b0;
            rd_seen_q  <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            state_q    <= state_d;
            psc_cnt_q  <= psc_cnt_d;
            tick_cnt_q <= tick_cnt_d;
            phase_y_q  <= phase_y_d;
            rd_seen_q  <= rd_seen_d;
            irq_q      <= irq_d;
        end
    end

    assign conv_interrupt = irq_q;

    // Pad switches, channel and touch detection
    always_comb begin
        pads_d      = '0;
        chan_d      = ctrl_q.chan;                                   // R1 R16
        touch_irq_d = 1'b0;
        if (axis_on && !axis_y) begin
            pads_d.xp_drive = 1'b1;                                  // R4
            pads_d.xm_drive = 1'b1;
            chan_d          = `ATS_CHAN_YP;
        end else if (axis_on) begin
            pads_d.yp_drive = 1'b1;                                  // R4
            pads_d.ym_drive = 1'b1;
            chan_d          = `ATS_CHAN_XP;
        end else begin
            // Minus pads float unless enabled, free as analog inputs
            pads_d.xp_drive  = ~tsc_q.xp_dis_n;                      // R15
            pads_d.xm_drive  = tsc_q.xm_en;                          // R15
            pads_d.yp_drive  = ~tsc_q.yp_dis_n;
            pads_d.ym_drive  = tsc_q.ym_en;
            pads_d.xp_pullup = ~tsc_q.pull_dis_n;
        end
        // Edge toward the selected stylus level
        if (tsc_q.pos == ats_pkg::ATS_POS_WAIT && !tsc_q.auto_seq) begin
            touch_irq_d = tsc_q.ud_sel ? (stylus_q & ~stylus_down)
                                       : (~stylus_q & stylus_down);  // R9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pads_q      <= '0;
            chan_q      <= 3'h0;
            stylus_q    <= 1'b0;
            touch_irq_q <= 1'b0;
        end else begin
            pads_q      <= pads_d;
            chan_q      <= chan_d;
            stylus_q    <= stylus_down;
            touch_irq_q <= touch_irq_d;
        end
    end

    assign pads            = pads_q;
    assign conv_channel    = chan_q;
    assign touch_interrupt = touch_irq_q;

endmodule // ats_top

`default_nettype wire

/* testbench/ats_core_model.sv */
/*
 Behavioural analog core and touch panel facing ats_top.
 Assumes the bench sets pen as the stylus level.
*/
`timescale 1ns/1ps
`default_nettype none

module ats_core_model (
    // Converter interface
    input  wire logic               conv_busy,
    input  wire logic [2:0]         conv_channel,
    input  wire ats_pkg::ats_pads_t pads,
    output logic [9:0]              conv_code,
    // Panel
    input  wire logic               pen,
    output logic                    stylus_down
);
    logic [9:0] level;

    // Code carries channel and pad state, inverted while idle
    assign level       = {conv_channel, pads, 2'h1};
    assign conv_code   = conv_busy ? level : ~level;
    // Comparator follows the stylus
    assign stylus_down = pen;
endmodule // ats_core_model

`default_nettype wire

/* testbench/ats_top_chk.sv */
/*
 Port checker of the converter and touch screen block.
 Assumes it is bound onto ats_top.
*/
`timescale 1ns/1ps
`default_nettype none

module ats_top_chk (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Converter and interrupts
    input  wire logic        conv_tick,
    input  wire logic        conv_busy,
    input  wire logic        conv_interrupt,
    input  wire logic        touch_interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic acc;
    logic mapped;

    // Access phase and offset decode
    assign acc    = psel && penable;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h00C, 12'h010};

    // Bus answer
    zero_wait_a: assert property (acc |-> pready) else $error("pready missing");
    ready_idle_a: assert property (!acc |-> !pready) else $error("pready outside access");
    bad_addr_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0) else $error("unmapped answer");
    good_addr_a: assert property (acc && mapped |-> !pslverr) else $error("mapped error");
    // Converter interface
    tick_busy_a: assert property (conv_tick |-> conv_busy) else $error("tick while idle");
    int_after_a: assert property (conv_interrupt |-> !conv_busy && $past(conv_busy)) else $error("early irq");
    int_pulse_a: assert property (conv_interrupt |=> !conv_interrupt) else $error("long irq");
    touch_pulse_a: assert property (touch_interrupt |=> !touch_interrupt) else $error("long touch irq");

    // Main scenarios
    cover property (conv_interrupt);
    cover property (touch_interrupt);
    cover property (acc && pslverr);
endmodule // ats_top_chk

bind ats_top ats_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_tick(conv_tick),
    .conv_busy(conv_busy), .conv_interrupt(conv_interrupt), .touch_interrupt(touch_interrupt));

`default_nettype wire

/* testbench/ats_top_test.sv */
/*
 Self-checking bench of ats_top with the analog core model.
 Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ats_map.svh"

module ats_top_test;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic               pen = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               conv_tick;
    logic               conv_busy;
    logic [2:0]         conv_channel;
    logic [9:0]         conv_code;
    ats_pkg::ats_pads_t pads;
    logic               stylus_down;
    logic               conv_interrupt;
    logic               touch_interrupt;
    logic [31:0]        r;
    logic               e;
    int                 miscompares = 0;
    int                 compares = 0;
    int                 ticks = 0;
    int                 ints = 0;
    int                 touches = 0;
    int                 t0;
    int                 i0;

    always #5 pclk = ~pclk;

    // Event counters
    always @(posedge pclk) begin
        if (conv_tick === 1'b1) ticks++;
        if (conv_interrupt === 1'b1) ints++;
        if (touch_interrupt === 1'b1) touches++;
    end

    ats_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_tick(conv_tick), .conv_busy(conv_busy), .conv_channel(conv_channel),
        .conv_code(conv_code), .pads(pads), .stylus_down(stylus_down),
        .conv_interrupt(conv_interrupt), .touch_interrupt(touch_interrupt));

    ats_core_model model_u (.conv_busy(conv_busy), .conv_channel(conv_channel), .pads(pads),
        .conv_code(conv_code), .pen(pen), .stylus_down(stylus_down));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) miscompares++;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        check(r, want);
    endtask

    task automatic start_conv(input logic [31:0] ctl);
        t0 = ticks;
        i0 = ints;
        apb(1'b1, `ATS_OFF_CTRL, ctl);
    endtask

    // Waits for the interrupt, then counts ticks, cycles and pulses
    task automatic finish(input int nt, input int ncyc);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (conv_interrupt !== 1'b1 && n < 1000);
        repeat (3) @(posedge pclk);
        check(ticks - t0, nt);
        check(ints - i0, 1);
        if (ncyc > 0) check(n, ncyc);
    endtask

    task automatic t_reset;
        rd(`ATS_OFF_CTRL, 32'h3FC4);
        rd(`ATS_OFF_TSC, 32'h058);
        rd(`ATS_OFF_DAT0, 32'h0);
        rd(`ATS_OFF_DAT1, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check(e, 1'b1);
        check(r, 32'h0);
    endtask

    task automatic t_normal;
        start_conv(32'h49D1);
        rd(`ATS_OFF_CTRL, 32'h49D0);
        finish(5, 198);
        rd(`ATS_OFF_CTRL, 32'hC9D0);
        rd(`ATS_OFF_DAT0, 32'h101);
        apb(1'b1, `ATS_OFF_DAT0, 32'h0);
        start_conv(32'h4C51);
        finish(5, 251);
    endtask

    task automatic t_standby;
        start_conv(32'h49D5);
        repeat (60) @(posedge pclk);
        check(ticks - t0, 0);
        rd(`ATS_OFF_DAT0, 32'h101);
    endtask

    task automatic t_prescale_off;
        start_conv(32'h09E1);
        repeat (60) @(posedge pclk);
        check(ticks - t0, 0);
        apb(1'b1, `ATS_OFF_CTRL, 32'h49E0);
        finish(5, 0);
        rd(`ATS_OFF_DAT0, 32'h201);
    endtask

    task automatic t_positions;
        apb(1'b1, `ATS_OFF_TSC, 32'h059);
        start_conv(32'h49C1);
        finish(5, 201);
        rd(`ATS_OFF_DAT0, 32'h2E1);
        rd(`ATS_OFF_DAT1, 32'h0);
        apb(1'b1, `ATS_OFF_TSC, 32'h05A);
        start_conv(32'h49C1);
        finish(5, 201);
        rd(`ATS_OFF_DAT1, 32'h399);
        rd(`ATS_OFF_DAT0, 32'h2E1);
        apb(1'b1, `ATS_OFF_TSC, 32'h05C);
        start_conv(32'h49C1);
        finish(10, 0);
        rd(`ATS_OFF_DAT0, 32'h2E1);
        rd(`ATS_OFF_DAT1, 32'h399);
    endtask

    task automatic t_read_start;
        apb(1'b1, `ATS_OFF_TSC, 32'h058);
        start_conv(32'h49C3);
        repeat (60) @(posedge pclk);
        check(ticks - t0, 0);
        apb(1'b0, `ATS_OFF_DAT0, 32'h0);
        finish(5, 201);
    endtask

    task automatic t_touch;
        int t;
        apb(1'b1, `ATS_OFF_TSC, 32'h0D3);
        repeat (2) @(posedge pclk);
        check(pads, 5'h03);
        t = touches;
        pen <= 1'b1;
        repeat (4) @(posedge pclk);
        check(touches - t, 1);
        pen <= 1'b0;
        repeat (4) @(posedge pclk);
        check(touches - t, 1);
        apb(1'b1, `ATS_OFF_TSC, 32'h058);
    endtask

    task automatic final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_normal;
        t_standby;
        t_prescale_off;
        t_positions;
        t_read_start;
        t_touch;
        final_report;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report;
    end
endmodule // ats_top_test

`default_nettype wire
